// ==== boje_params.svh ====
// Purpose: constants for the byte-operation and jump execute block
// Assumes: one instruction issued per accepted cycle
// Notes: all widths and encodings shared by package and modules
//
// What this block does
// - Complement: inverted register goes to accumulator or register, zero flag updated.
// - Clear-register writes zero to the register and sets the zero flag.
// - Clear-accumulator loads zero into the accumulator and sets the zero flag.
// - Decrement: register minus one to selected destination, zero flag updated.
// - Decrement-skip: no flag change; zero result squashes next instruction, two cycles.
// - Jump: literal into counter bits 10..0, latch bits 4..3 into 12..11.
// - Jump takes two instruction cycles.
// - Increment: register plus one to selected destination, zero flag updated.
`ifndef BOJE_PARAMS_SVH
`define BOJE_PARAMS_SVH
`define BOJE_DATA_W      8
`define BOJE_FADDR_W     7
`define BOJE_CNT_W       13
`define BOJE_LIT_W       11
`define BOJE_LATCH_W     5
`define BOJE_LATCH_HI    4
`define BOJE_LATCH_LO    3
`define BOJE_OP_W        3
`define BOJE_OP_COMP     3'h0
`define BOJE_OP_CLR_REG  3'h1
`define BOJE_OP_CLR_ACC  3'h2
`define BOJE_OP_DEC      3'h3
`define BOJE_OP_DECSKIP  3'h4
`define BOJE_OP_INC      3'h5
`define BOJE_OP_JUMP     3'h6
`define BOJE_OP_NOP      3'h7
`define BOJE_ZERO_BYTE   8'h00
`define BOJE_ONE_BYTE    8'h01
`define BOJE_CNT_RESET   13'h0000
`define BOJE_DEST_ACC    1'b0
`endif

// ==== boje_pkg.sv ====
// Purpose: types for the byte-operation and jump execute block
// Assumes: boje_params.svh constants
// Notes: request and result travel as packed structs
`default_nettype none
`include "boje_params.svh"
package boje_pkg;
  // Issued instruction
  typedef struct packed {
    logic                      valid;
    logic [`BOJE_OP_W-1:0]     op;
    logic                      dest;
    logic [`BOJE_FADDR_W-1:0]  faddr;
    logic [`BOJE_DATA_W-1:0]   fdata;
    logic [`BOJE_LIT_W-1:0]    lit;
  } boje_req_t;
  // Write-back of one cycle
  typedef struct packed {
    logic                      reg_we;
    logic [`BOJE_FADDR_W-1:0]  reg_addr;
    logic [`BOJE_DATA_W-1:0]   reg_data;
    logic                      acc_we;
    logic [`BOJE_DATA_W-1:0]   acc_data;
    logic                      zero_we;
    logic                      zero_val;
  } boje_wb_t;
  // Combinational result of the byte unit
  typedef struct packed {
    logic [`BOJE_DATA_W-1:0]   value;
    logic                      is_zero;
  } boje_alu_t;
endpackage
`default_nettype wire

// ==== boje_alu.sv ====
// Purpose: byte arithmetic for complement, clear, decrement, increment
// Assumes: operand is the addressed register contents
// Notes: pure combinational, wraps modulo 256
`include "boje_params.svh"
`timescale 1ns/1ns
`default_nettype none
module boje_alu
  import boje_pkg::*;
(
  // Operation and operand
  input  wire logic [`BOJE_OP_W-1:0]   op,
  input  wire logic [`BOJE_DATA_W-1:0] operand,
  // Result
  output var boje_alu_t                res
);
  // ==========================================================
  // Result select
  always_comb begin
    res.value = `BOJE_ZERO_BYTE;
    unique case (op)
      `BOJE_OP_COMP:    res.value = ~operand;
      `BOJE_OP_DEC,
      `BOJE_OP_DECSKIP: res.value = operand - `BOJE_ONE_BYTE;
      `BOJE_OP_INC:     res.value = operand + `BOJE_ONE_BYTE;
      default:          res.value = `BOJE_ZERO_BYTE;
    endcase
    res.is_zero = (res.value == `BOJE_ZERO_BYTE);
  end
endmodule
`default_nettype wire

// ==== boje_exec.sv ====
// Purpose: execute stage for complement, clears, dec, dec-skip, inc, jump
// Assumes: decoder holds next instruction while busy is high
// Notes: second cycle of jump or skip executes as a no-operation
`include "boje_params.svh"
`timescale 1ns/1ns
`default_nettype none
module boje_exec
  import boje_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Instruction request
  input  wire boje_req_t                 req,
  input  wire logic [`BOJE_LATCH_W-1:0]  upper_page_latch,
  // Write-back to register file, accumulator, status
  output var boje_wb_t                   wb,
  // Program counter load
  output logic                           counter_load,
  output logic [`BOJE_CNT_W-1:0]         program_counter,
  // Flush of fetched instruction and stall
  output logic                           flush,
  output logic                           busy
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    BOJE_RUN  = 2'b01,
    BOJE_BUBB = 2'b10
  } boje_state_t;

  boje_state_t state;
  boje_state_t next_state;
  boje_alu_t   alu;
  logic        take;
  logic        two_cycle;

  // Operation decode used in several places
  function automatic logic is_op(input logic [`BOJE_OP_W-1:0] a,
                                 input logic [`BOJE_OP_W-1:0] b);
    is_op = (a == b);
  endfunction

  boje_alu u_alu (
    .op      (req.op),
    .operand (req.fdata),
    .res     (alu)
  );

  // ==========================================================
  // Accept and cycle count
  assign take      = req.valid && (state == BOJE_RUN);
  assign two_cycle = is_op(req.op, `BOJE_OP_JUMP) ||
                     (is_op(req.op, `BOJE_OP_DECSKIP) && alu.is_zero);

  always_comb begin
    next_state = state;
    unique case (state)
      BOJE_RUN:  if (take && two_cycle) next_state = BOJE_BUBB;
      BOJE_BUBB: next_state = BOJE_RUN;
      default:   next_state = BOJE_RUN;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) state <= BOJE_RUN;
    else        state <= next_state;
  end

  // Busy marks the no-operation cycle
  always_ff @(posedge clk) begin
    if (!rst_n) busy <= 1'b0;
    else        busy <= take && two_cycle;
  end

  // Flush pulse discards the fetched instruction
  always_ff @(posedge clk) begin
    if (!rst_n) flush <= 1'b0;
    else        flush <= take && two_cycle;
  end

  // ==========================================================
  // Data write-back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb <= '0;
    end else begin
      wb          <= '0;
      wb.reg_addr <= req.faddr;
      wb.reg_data <= alu.value;
      wb.acc_data <= alu.value;
      wb.zero_val <= alu.is_zero;
      if (take) begin
        unique case (req.op)
          `BOJE_OP_COMP, `BOJE_OP_DEC, `BOJE_OP_INC: begin
            wb.reg_we  <= (req.dest != `BOJE_DEST_ACC);
            wb.acc_we  <= (req.dest == `BOJE_DEST_ACC);
            wb.zero_we <= 1'b1;
          end
          `BOJE_OP_DECSKIP: begin
            wb.reg_we  <= (req.dest != `BOJE_DEST_ACC);
            wb.acc_we  <= (req.dest == `BOJE_DEST_ACC);
          end
          `BOJE_OP_CLR_REG: begin
            wb.reg_we   <= 1'b1;
            wb.zero_we  <= 1'b1;
            wb.zero_val <= 1'b1;
          end
          `BOJE_OP_CLR_ACC: begin
            wb.acc_we   <= 1'b1;
            wb.zero_we  <= 1'b1;
            wb.zero_val <= 1'b1;
          end
          default: begin
            wb.reg_we <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Jump target
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_load    <= 1'b0;
      program_counter <= `BOJE_CNT_RESET;
    end else begin
      counter_load <= take && is_op(req.op, `BOJE_OP_JUMP);
      if (take && is_op(req.op, `BOJE_OP_JUMP))
        program_counter <= {upper_page_latch[`BOJE_LATCH_HI:`BOJE_LATCH_LO],
                            req.lit};
    end
  end

  // ==========================================================
  // Checks
  // Named steps of the two-cycle instructions
  sequence s_jump_taken;
    take && is_op(req.op, `BOJE_OP_JUMP);
  endsequence
  sequence s_skip_taken;
    take && is_op(req.op, `BOJE_OP_DECSKIP) && alu.is_zero;
  endsequence
  sequence s_one_bubble;
    busy && flush && !take ##1 !busy;
  endsequence

  // Jump target and length
  a_jump_target: assert property (@(posedge clk) disable iff (!rst_n)
    s_jump_taken |=> counter_load && program_counter ==
      {$past(upper_page_latch[`BOJE_LATCH_HI:`BOJE_LATCH_LO]), $past(req.lit)})
    else $error("jump target wrong");
  a_jump_two_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    s_jump_taken |=> s_one_bubble)
    else $error("jump not two cycles");
  a_jump_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
    s_jump_taken |=> !wb.zero_we && !wb.reg_we && !wb.acc_we)
    else $error("jump touched data");
  a_target_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !counter_load && $past(rst_n) |-> $stable(program_counter))
    else $error("jump target drifted");

  // Skip decision
  a_skip_bubble: assert property (@(posedge clk) disable iff (!rst_n)
    s_skip_taken |=> (!wb.zero_we ##0 s_one_bubble))
    else $error("skip not inserted");
  a_noskip_run: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_DECSKIP) && !alu.is_zero |=> !busy && !flush)
    else $error("spurious skip");
  a_dskip_value: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_DECSKIP) |=> !wb.zero_we
      && wb.reg_data == $past(req.fdata) - 8'h01 && (wb.reg_we == $past(req.dest)))
    else $error("decrement-skip write wrong");

  // Clears
  a_clear_reg: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_CLR_REG) |=> wb.reg_we && wb.reg_data == 8'h00
      && wb.zero_we && wb.zero_val)
    else $error("clear register wrong");
  a_clear_acc: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_CLR_ACC) |=> wb.acc_we && wb.acc_data == 8'h00
      && wb.zero_val && !wb.reg_we)
    else $error("clear accumulator wrong");

  // Complement, decrement, increment
  a_comp_value: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_COMP) |=> wb.acc_data == ~$past(req.fdata)
      && wb.zero_we && (wb.acc_we == !$past(req.dest)))
    else $error("complement wrong");
  a_comp_reg: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_COMP) |=> wb.reg_data == ~$past(req.fdata)
      && (wb.reg_we == $past(req.dest)))
    else $error("complement register write wrong");
  a_dec_value: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_DEC) |=> wb.reg_data == $past(req.fdata) - 8'h01
      && (wb.reg_we == $past(req.dest)))
    else $error("decrement wrong");
  a_dec_dest: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_DEC) |=> wb.acc_data == $past(req.fdata) - 8'h01
      && (wb.acc_we == !$past(req.dest)) && wb.zero_we)
    else $error("decrement destination wrong");
  a_inc_value: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_INC) |=> wb.reg_data == $past(req.fdata) + 8'h01
      && wb.zero_we)
    else $error("increment wrong");
  a_inc_dest: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_op(req.op, `BOJE_OP_INC) |=> (wb.reg_we == $past(req.dest))
      && (wb.acc_we == !$past(req.dest)) && wb.acc_data == $past(req.fdata) + 8'h01)
    else $error("increment destination wrong");

  // Zero flag and quiet cycles
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    wb.zero_we |-> wb.zero_val == (wb.acc_data == 8'h00))
    else $error("zero flag wrong");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !take |=> !wb.reg_we && !wb.acc_we && !wb.zero_we && !counter_load && !busy)
    else $error("output without instruction");
endmodule
`default_nettype wire

// ==== byte_op_and_jump_execute_tb.sv ====
// Purpose: self-checking bench for the byte-operation and jump execute stage
// Assumes: one instruction presented per cycle, outputs one cycle after taking
// Notes: driver queues expected outputs, monitor compares them every cycle
`include "boje_params.svh"
`timescale 1ns/1ns
`default_nettype none
module byte_op_and_jump_execute_tb
  import boje_pkg::*;
;
  // ==========================================================================
  // Signals and expectation record
  typedef struct packed {
    boje_wb_t                wb;
    logic                    counter_load;
    logic [`BOJE_CNT_W-1:0]  tgt;
    logic                    flush;
    logic                    busy;
  } boje_exp_t;
  logic                      clk;
  logic                      rst_n;
  boje_req_t                 req;
  logic [`BOJE_LATCH_W-1:0]  latch;
  boje_wb_t                  wb;
  logic                      counter_load;
  logic [`BOJE_CNT_W-1:0]    program_counter;
  logic                      flush;
  logic                      busy;
  boje_exp_t                 exp_q[$];
  boje_exp_t                 pend;
  logic                      m_busy;
  logic [`BOJE_CNT_W-1:0]    m_tgt;
  int                        failures;
  int                        n_checks;
  int                        seed;
  logic [31:0]               rnd;

  boje_exec u_boje_exec (.clk(clk), .rst_n(rst_n), .req(req), .upper_page_latch(latch),
    .wb(wb), .counter_load(counter_load), .program_counter(program_counter), .flush(flush),
    .busy(busy));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever begin
      #5 clk = ~clk;
    end
  end

  // ==========================================================================
  // Compare, model and drive tasks
  task automatic check_val(input string name, input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  // Write-back results of one cycle
  task automatic compare_wb(input boje_wb_t e);
    check_val("reg_we", 13'(e.reg_we), 13'(wb.reg_we));
    check_val("acc_we", 13'(e.acc_we), 13'(wb.acc_we));
    check_val("zero_we", 13'(e.zero_we), 13'(wb.zero_we));
    if (e.reg_we) begin
      check_val("reg_addr", 13'(e.reg_addr), 13'(wb.reg_addr));
      check_val("reg_data", 13'(e.reg_data), 13'(wb.reg_data));
    end
    if (e.acc_we) check_val("acc_data", 13'(e.acc_data), 13'(wb.acc_data));
    if (e.zero_we) check_val("zero_val", 13'(e.zero_val), 13'(wb.zero_val));
  endtask

  // Jump results
  task automatic compare_jump(input boje_exp_t e);
    check_val("counter_load", 13'(e.counter_load), 13'(counter_load));
    check_val("program_counter", e.tgt, program_counter);
  endtask

  // Stall results
  task automatic compare_stall(input boje_exp_t e);
    check_val("flush", 13'(e.flush), 13'(flush));
    check_val("busy", 13'(e.busy), 13'(busy));
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Expected outputs for the request taken at the next edge
  task automatic model(input boje_req_t r, input logic [4:0] lat);
    logic [7:0] v;
    v = r.fdata;
    pend = '0;
    pend.tgt = m_tgt;
    if (r.valid && !m_busy) begin
      case (r.op)
        `BOJE_OP_COMP: v = ~r.fdata;
        `BOJE_OP_DEC, `BOJE_OP_DECSKIP: v = r.fdata - 8'h01;
        `BOJE_OP_INC: v = r.fdata + 8'h01;
        default: v = 8'h00;
      endcase
      pend.wb.reg_addr = r.faddr;
      pend.wb.reg_data = v;
      pend.wb.acc_data = v;
      pend.wb.zero_val = (v == 8'h00);
      case (r.op)
        `BOJE_OP_CLR_REG: pend.wb.reg_we = 1'b1;
        `BOJE_OP_CLR_ACC: pend.wb.acc_we = 1'b1;
        `BOJE_OP_NOP: pend.wb.reg_we = 1'b0;
        `BOJE_OP_JUMP: begin
          pend.counter_load = 1'b1;
          pend.tgt = {lat[`BOJE_LATCH_HI:`BOJE_LATCH_LO], r.lit};
        end
        default: begin
          pend.wb.reg_we = r.dest;
          pend.wb.acc_we = ~r.dest;
        end
      endcase
      pend.wb.zero_we = (r.op <= `BOJE_OP_DEC) || (r.op == `BOJE_OP_INC);
      pend.busy = (r.op == `BOJE_OP_JUMP) || (r.op == `BOJE_OP_DECSKIP && v == 8'h00);
      pend.flush = pend.busy;
    end
    m_busy = pend.busy;
    m_tgt = pend.tgt;
  endtask

  task automatic step(input boje_req_t r, input logic [4:0] lat);
    @(posedge clk);
    req <= r;
    latch <= lat;
    exp_q.push_back(pend);
    model(r, lat);
  endtask

  // Mid-run reset: the taking edge, then one edge with reset low
  task automatic pulse_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    req <= '0;
    exp_q.push_back(pend);
    pend = '0;
    m_busy = 1'b0;
    m_tgt = `BOJE_CNT_RESET;
    @(posedge clk);
    rst_n <= 1'b1;
    exp_q.push_back(pend);
    model('0, 5'h00);
  endtask

  function automatic boje_req_t mk(input logic [2:0] op, input logic d, input logic [7:0] f);
    boje_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.dest = d;
    r.fdata = f;
    r.faddr = 7'h55;
    r.lit = 11'h123;
    return r;
  endfunction

  // ==========================================================================
  // Monitor: one expectation per cycle
  initial begin
    boje_exp_t e;
    forever begin
      @(posedge clk);
      #1;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        compare_wb(e.wb);
        compare_jump(e);
        compare_stall(e);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence: boundary cases, refusals, then random traffic
  initial begin
    rst_n = 1'b0;
    req = '0;
    latch = '0;
    pend = '0;
    m_busy = 1'b0;
    m_tgt = '0;
    failures = 0;
    n_checks = 0;
    seed = 89;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      step(mk(`BOJE_OP_INC, d[0], 8'hff), 5'h18);
      step(mk(`BOJE_OP_DEC, d[0], 8'h00), 5'h18);
      step(mk(`BOJE_OP_DEC, d[0], 8'h01), 5'h18);
      step(mk(`BOJE_OP_COMP, d[0], 8'hff), 5'h18);
      step(mk(`BOJE_OP_COMP, d[0], 8'h5a), 5'h18);
      step(mk(`BOJE_OP_CLR_REG, d[0], 8'h77), 5'h18);
      step(mk(`BOJE_OP_CLR_ACC, d[0], 8'h77), 5'h18);
      step(mk(`BOJE_OP_DECSKIP, d[0], 8'h00), 5'h18);
      step(mk(`BOJE_OP_DECSKIP, d[0], 8'h01), 5'h18);
      step(mk(`BOJE_OP_INC, d[0], 8'h10), 5'h18);
      step(mk(`BOJE_OP_JUMP, d[0], 8'h00), 5'h18);
      step(mk(`BOJE_OP_JUMP, d[0], 8'h00), 5'h07);
      step(mk(`BOJE_OP_NOP, d[0], 8'h00), 5'h07);
    end
    step(mk(`BOJE_OP_JUMP, 1'b1, 8'h00), 5'h18);
    pulse_reset();
    for (int i = 0; i < 600; i++) begin
      rnd = $random(seed);
      step(boje_req_t'({rnd[31] | rnd[30], rnd[29:0]}), 5'($random(seed)));
    end
    repeat (3) step('0, 5'h00);
    for (int w = 0; w < 8 && exp_q.size() > 0; w++) @(posedge clk);
    if (exp_q.size() > 0) failures++;
    complete_run();
  end
endmodule
`default_nettype wire
